// file: logic/ftac_defs.vh
// Constants for the flight-time averaging cycle counter
`ifndef FTAC_DEFS_VH
`define FTAC_DEFS_VH
`define FTAC_ADDR_W        8
`define FTAC_REG_TALLY     8'hE4
`define FTAC_REG_AVG_INT   8'hE5
`define FTAC_REG_AVG_FRAC  8'hE6
`define FTAC_REG_TARGET    8'hF0
`define FTAC_REG_STATUS    8'hF1
`define FTAC_REG_MASK      8'hF2
`define FTAC_TALLY_RST     8'h00
`define FTAC_TARGET_RST    8'h01
`define FTAC_MASK_RST      2'h0
`define FTAC_STATUS_RST    2'h0
`define FTAC_AVG_RST       16'h0000
`define FTAC_RD_IDLE       16'h0000
`define FTAC_BIT_DONE      0
`define FTAC_BIT_DIVDONE   1
`define FTAC_ST_IDLE       2'h0
`define FTAC_ST_RUN        2'h1
`define FTAC_ST_DIV        2'h2
`endif

// file: logic/ftac_divider.v
// Signed restoring divider for the average of the summed results
`timescale 1ns/1ps
`default_nettype none
module ftac_divider #(
  parameter SUM_W = 24,
  parameter DIV_W = 8
) (
  // Clock and reset
  input  wire               core_clk,
  input  wire               srst,
  // Request
  input  wire               start,
  input  wire [SUM_W-1:0]   dividend,
  input  wire [DIV_W-1:0]   divisor,
  // Result
  output wire               busy,
  output reg                doneQ,
  output reg  [SUM_W-1:0]   quotQ,
  output reg  [15:0]        fracQ
);
  localparam CNT_W = 6;
  localparam [CNT_W-1:0] STEPS = SUM_W + 16;

  reg [SUM_W+15:0]  numQ;
  reg [DIV_W:0]     remQ;
  reg [DIV_W-1:0]   denQ;
  reg               negQ;
  reg [CNT_W-1:0]   cntQ;
  wire [DIV_W:0]    remShift;
  wire [DIV_W:0]    remSub;
  wire [SUM_W+15:0] res;
  wire [SUM_W+15:0] resNeg;

  assign busy     = (cntQ != {CNT_W{1'b0}});
  assign remShift = {remQ[DIV_W-1:0], numQ[SUM_W+15]};
  assign remSub   = remShift - {1'b0, denQ};
  assign res      = {numQ[SUM_W+14:0], ~remSub[DIV_W]};
  assign resNeg   = ~res + {{(SUM_W+15){1'b0}}, 1'b1};

  always @(posedge core_clk) begin
    doneQ <= 1'b0;
    if (srst) begin
      numQ  <= {(SUM_W+16){1'b0}};
      remQ  <= {(DIV_W+1){1'b0}};
      denQ  <= {DIV_W{1'b0}};
      negQ  <= 1'b0;
      cntQ  <= {CNT_W{1'b0}};
      quotQ <= {SUM_W{1'b0}};
      fracQ <= 16'h0000;
    end else if (start && !busy) begin
      // Work on magnitude, fraction bits appended below the point
      negQ  <= dividend[SUM_W-1];
      numQ  <= {(dividend[SUM_W-1] ? (~dividend + {{(SUM_W-1){1'b0}}, 1'b1})
                                   : dividend), 16'h0000};
      remQ  <= {(DIV_W+1){1'b0}};
      denQ  <= divisor;
      cntQ  <= STEPS;
    end else if (busy) begin
      remQ <= remSub[DIV_W] ? remShift : remSub;
      numQ <= res;
      cntQ <= cntQ - {{(CNT_W-1){1'b0}}, 1'b1};
      if (cntQ == {{(CNT_W-1){1'b0}}, 1'b1}) begin
        doneQ <= 1'b1;
        quotQ <= negQ ? resNeg[SUM_W+15:16] : res[SUM_W+15:16];
        fracQ <= negQ ? resNeg[15:0] : res[15:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/ftac_cycle_counter.v
// Averaging cycle tally with accumulation, averaging and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ftac_defs.vh"
module ftac_cycle_counter #(
  parameter TALLY_W = 8,
  parameter DIFF_W  = 16
) (
  // Clock and reset
  input  wire                    core_clk,
  input  wire                    srst,
  // Register port
  input  wire [`FTAC_ADDR_W-1:0] regAddr,
  input  wire [15:0]             regWrData,
  input  wire                    regWrEn,
  input  wire                    regRdEn,
  output reg  [15:0]             regRdDataQ,
  // Measurement engine
  input  wire                    seqOneStart,
  input  wire                    seqTwoStart,
  input  wire                    cycleDone,
  input  wire                    cycleError,
  input  wire [DIFF_W-1:0]       diffFlightTime,
  // Interrupt
  output wire                    irq
);
  // Wide enough for a full tally of full-scale results
  localparam SUM_W = DIFF_W + TALLY_W;

  reg  [1:0]         stateQ;
  reg  [TALLY_W-1:0] tallyQ;
  reg  [TALLY_W-1:0] issuedQ;
  reg  [TALLY_W-1:0] targetQ;
  reg  [SUM_W-1:0]   sumQ;
  reg  [15:0]        avgIntQ;
  reg  [15:0]        avgFracQ;
  reg  [1:0]         statusQ;
  reg  [1:0]         maskQ;
  reg                divStartQ;
  wire               divDone;
  wire [SUM_W-1:0]   divQuot;
  wire [15:0]        divFrac;
  wire               seqStart;
  wire               lastCycle;
  reg  [1:0]         setEv;
  reg  [15:0]        regRdDataD;
  wire               wrStatus;
  wire               wrMask;
  wire               wrTarget;
  wire               tallyZero;

  // Sign-extend a differential result to the accumulator width
  function [SUM_W-1:0] sext;
    input [DIFF_W-1:0] v;
    begin
      sext = {{TALLY_W{v[DIFF_W-1]}}, v};
    end
  endfunction

  // Wrap-around increment shared by the counters
  function [TALLY_W-1:0] inc;
    input [TALLY_W-1:0] v;
    begin
      inc = v + {{(TALLY_W-1){1'b0}}, 1'b1};
    end
  endfunction

  assign seqStart  = seqOneStart | seqTwoStart;
  // Issue count, not tally, ends the sequence
  assign lastCycle = cycleDone && inc(issuedQ) == targetQ;
  assign wrStatus  = regWrEn && regAddr == `FTAC_REG_STATUS;
  assign wrMask    = regWrEn && regAddr == `FTAC_REG_MASK;
  // Target held while a sequence runs to keep the count coherent
  assign wrTarget  = regWrEn && regAddr == `FTAC_REG_TARGET &&
                     stateQ == `FTAC_ST_IDLE;
  assign tallyZero = tallyQ == {TALLY_W{1'b0}};

  always @(posedge core_clk) begin
    divStartQ <= 1'b0;
    if (srst) begin
      stateQ  <= `FTAC_ST_IDLE;
      tallyQ  <= `FTAC_TALLY_RST;
      issuedQ <= {TALLY_W{1'b0}};
      sumQ    <= {SUM_W{1'b0}};
    end else begin
      case (stateQ)
        `FTAC_ST_IDLE: begin
          if (seqStart) begin
            tallyQ  <= `FTAC_TALLY_RST;
            issuedQ <= {TALLY_W{1'b0}};
            sumQ    <= {SUM_W{1'b0}};
            stateQ  <= `FTAC_ST_RUN;
          end
        end
        `FTAC_ST_RUN: begin
          if (cycleDone) begin
            // Errored cycles still use up the target
            issuedQ <= inc(issuedQ);
            if (!cycleError) begin
              tallyQ <= inc(tallyQ);
              sumQ   <= sumQ + sext(diffFlightTime);
            end
            if (lastCycle) begin
              divStartQ <= 1'b1;
              stateQ    <= `FTAC_ST_DIV;
            end
          end
        end
        `FTAC_ST_DIV: begin
          if (divDone)
            stateQ <= `FTAC_ST_IDLE;
        end
        default: stateQ <= `FTAC_ST_IDLE;
      endcase
    end
  end

  // Averages settle about forty cycles after the last cycle
  // tally is the divisor
  ftac_divider #(
    .SUM_W (SUM_W),
    .DIV_W (TALLY_W)
  ) uDiv (
    .core_clk (core_clk),
    .srst     (srst),
    .start    (divStartQ),
    .dividend (sumQ),
    .divisor  (tallyQ),
    .busy     (),
    .doneQ    (divDone),
    .quotQ    (divQuot),
    .fracQ    (divFrac)
  );

  // Zero tally would divide by zero; report zero average instead
  always @(posedge core_clk) begin
    if (srst) begin
      avgIntQ  <= `FTAC_AVG_RST;
      avgFracQ <= `FTAC_AVG_RST;
    end else if (divDone) begin
      if (tallyZero) begin
        avgIntQ  <= `FTAC_AVG_RST;
        avgFracQ <= `FTAC_AVG_RST;
      end else begin
        avgIntQ  <= divQuot[15:0];
        avgFracQ <= divFrac;
      end
    end
  end

  // Bit 1 rises once the averages are ready
  always @* begin
    setEv = 2'h0;
    setEv[`FTAC_BIT_DONE]    = stateQ == `FTAC_ST_RUN && lastCycle;
    setEv[`FTAC_BIT_DIVDONE] = divDone;
  end

  // Set wins over write-one-to-clear
  always @(posedge core_clk) begin
    if (srst)
      statusQ <= `FTAC_STATUS_RST;
    else if (wrStatus)
      statusQ <= (statusQ & ~regWrData[1:0]) | setEv;
    else
      statusQ <= statusQ | setEv;
  end

  // Target 0 wraps the issue count, so it means 256 cycles
  always @(posedge core_clk) begin
    if (srst) begin
      maskQ   <= `FTAC_MASK_RST;
      targetQ <= `FTAC_TARGET_RST;
    end else begin
      if (wrMask)
        maskQ <= regWrData[1:0];
      if (wrTarget)
        targetQ <= regWrData[TALLY_W-1:0];
    end
  end

  assign irq = |(statusQ & maskQ);

  // Idle cycles read as zero so the data bus can be OR-ed
  always @* begin
    regRdDataD = `FTAC_RD_IDLE;
    if (regRdEn) begin
      case (regAddr)
        `FTAC_REG_TALLY:    regRdDataD = {{(16-TALLY_W){1'b0}}, tallyQ};
        `FTAC_REG_AVG_INT:  regRdDataD = avgIntQ;
        `FTAC_REG_AVG_FRAC: regRdDataD = avgFracQ;
        `FTAC_REG_TARGET:   regRdDataD = {{(16-TALLY_W){1'b0}}, targetQ};
        `FTAC_REG_STATUS:   regRdDataD = {14'h0000, statusQ};
        `FTAC_REG_MASK:     regRdDataD = {14'h0000, maskQ};
        default:            regRdDataD = `FTAC_RD_IDLE;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (srst)
      regRdDataQ <= `FTAC_RD_IDLE;
    else
      regRdDataQ <= regRdDataD;
  end
endmodule
`default_nettype wire

// file: dv/ftac_cycle_counter_props.sv
// Port checker for the averaging cycle counter
`timescale 1ns/1ps
`default_nettype none
module ftac_cycle_counter_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // Observed ports
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [15:0] regRdDataQ,
  input wire logic        seqOneStart,
  input wire logic        seqTwoStart,
  input wire logic        cycleDone,
  input wire logic        cycleError,
  input wire logic        irq
);
  logic [7:0] cntQ, expQ, doneQ, tgtQ;
  logic [1:0] maskQ;
  logic       rdQ, rdTallyQ, rdStatQ, runQ;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Mirror of the running sequence; target writes blocked only until the last cycle, not while averaging
  always @(posedge core_clk) begin
    rdQ      <= regRdEn;
    rdTallyQ <= regRdEn && regAddr == 8'hE4;
    rdStatQ  <= regRdEn && regAddr == 8'hF1;
    expQ     <= cntQ;
    if (srst) begin
      runQ  <= 1'b0;
      cntQ  <= 8'h00;
      doneQ <= 8'h00;
      tgtQ  <= 8'h01;
      maskQ <= 2'h0;
    end else begin
      if (regWrEn && regAddr == 8'hF0 && !runQ) tgtQ <= regWrData[7:0];
      if (regWrEn && regAddr == 8'hF2) maskQ <= regWrData[1:0];
      if ((seqOneStart || seqTwoStart) && !runQ) begin
        runQ  <= 1'b1;
        cntQ  <= 8'h00;
        doneQ <= 8'h00;
      end else if (cycleDone && runQ) begin
        cntQ  <= cntQ + {7'h00, !cycleError};
        doneQ <= doneQ + 8'h01;
        if (doneQ == tgtQ - 8'h01) runQ <= 1'b0;
      end
    end
  end
  rd_idle_a: assert property (
    !rdQ |-> regRdDataQ == 16'h0000) else $error("read data not idle");
  tally_cnt_a: assert property (
    rdTallyQ |-> regRdDataQ == {8'h00, expQ}) else $error("tally wrong");
  irq_set_a: assert property (
    runQ && cycleDone && doneQ == tgtQ - 8'h01 && maskQ[0] |-> ##1 irq)
    else $error("done interrupt missing");
  irq_off_a: assert property (
    maskQ == 2'h0 |-> !irq) else $error("interrupt high while masked");
  irq_mask_a: assert property (
    regWrEn && regAddr == 8'hF2 && regWrData[1:0] == 2'h0 |=> !irq)
    else $error("masked interrupt high");
  stat_hi_a: assert property (
    rdStatQ |-> regRdDataQ[15:2] == 14'h0000) else $error("status high bits");
endmodule
`default_nettype wire

// file: dv/ftac_host_model.sv
// Register bus master standing in for the host
`timescale 1ns/1ps
`default_nettype none
module ftac_host_model (
  // Clock
  input  wire logic        core_clk,
  // Register port
  output logic [7:0]       regAddr,
  output logic [15:0]      regWrData,
  output logic             regWrEn,
  output logic             regRdEn,
  input  wire logic [15:0] regRdDataQ
);
  initial {regAddr, regWrData, regWrEn, regRdEn} = 26'h0000000;
  // Called just after a rising edge; never re-entered at the same edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    @(posedge core_clk);
    d = regRdDataQ;
  endtask
endmodule
`default_nettype wire

// file: dv/test_ftac_cycle_counter.sv
// Bench for the averaging cycle counter
`timescale 1ns/1ps
`default_nettype none
module test_ftac_cycle_counter;
  logic        core_clk, srst, seqOneStart, seqTwoStart, cycleDone;
  logic        cycleError, irq, regWrEn, regRdEn;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdDataQ, diffFlightTime, rdVal;
  int          miscompares = 0, checkCount = 0, cycles = 0;
  // Rows: target, error bits, difference, expected tally
  logic [7:0]  tgt [4] = '{8'h03, 8'h05, 8'h04, 8'h01};
  logic [7:0]  errs[4] = '{8'h07, 8'h0A, 8'h00, 8'h00};
  logic [15:0] dif [4] = '{16'h0005, 16'hFFF0, 16'h0010, 16'h7FFF};
  logic [7:0]  tal [4] = '{8'h00, 8'h03, 8'h04, 8'h01};
  ftac_cycle_counter dut_u (.core_clk(core_clk), .srst(srst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdDataQ(regRdDataQ), .seqOneStart(seqOneStart),
    .seqTwoStart(seqTwoStart), .cycleDone(cycleDone),
    .cycleError(cycleError), .diffFlightTime(diffFlightTime), .irq(irq));
  ftac_host_model host_u (.core_clk(core_clk), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdDataQ(regRdDataQ));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    host_u.rd(a, rdVal);
    chk(rdVal, e);
  endtask
  task automatic end_sim;
    if (miscompares == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Runs take about 470 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_sim;
    end
  end
  initial begin
    {srst, seqOneStart, seqTwoStart, cycleDone, cycleError} = 5'h10;
    diffFlightTime = 16'h0000;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    host_u.wr(8'hF2, 16'h0003);
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(8'hF0, {8'h00, tgt[i]});
      seqOneStart <= !i[0];
      seqTwoStart <= i[0];
      @(posedge core_clk);
      {seqOneStart, seqTwoStart} <= 2'h0;
      // Back-to-back cycle completions
      for (int k = 0; k < tgt[i]; k++) begin
        cycleDone      <= 1'b1;
        cycleError     <= errs[i][k];
        diffFlightTime <= dif[i];
        @(posedge core_clk);
      end
      cycleDone <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk({15'h0000, irq}, 16'h0001);
      repeat (60) @(posedge core_clk);
      rc(8'hF1, 16'h0003);
      rc(8'hE4, {8'h00, tal[i]});
      rc(8'hE5, tal[i] != 8'h00 ? dif[i] : 16'h0000);
      rc(8'hE6, 16'h0000);
      host_u.wr(8'hF1, 16'h0003);
      @(posedge core_clk);
      chk({15'h0000, irq}, 16'h0000);
    end
    host_u.wr(8'hF2, 16'h0000);
    seqTwoStart <= 1'b1;
    @(posedge core_clk);
    seqTwoStart <= 1'b0;
    cycleDone   <= 1'b1;
    @(posedge core_clk);
    cycleDone <= 1'b0;
    repeat (60) @(posedge core_clk);
    chk({15'h0000, irq}, 16'h0000);
    rc(8'hE4, 16'h0001);
    rc(8'hF1, 16'h0003);
    host_u.wr(8'hF2, 16'h0001);
    @(posedge core_clk);
    chk({15'h0000, irq}, 16'h0001);
    rc(8'h10, 16'h0000);
    // Negative half average, target refused mid-run, set beats clear
    host_u.wr(8'hF0, 16'h0002);
    seqOneStart <= 1'b1;
    @(posedge core_clk);
    seqOneStart    <= 1'b0;
    cycleDone      <= 1'b1;
    cycleError     <= 1'b0;
    diffFlightTime <= 16'hFFFF;
    host_u.wr(8'hF0, 16'h0005);
    cycleDone <= 1'b0;
    @(posedge core_clk);
    cycleDone      <= 1'b1;
    diffFlightTime <= 16'hFFFE;
    host_u.wr(8'hF1, 16'h0003);
    cycleDone <= 1'b0;
    rc(8'hF1, 16'h0001);
    repeat (50) @(posedge core_clk);
    rc(8'hE4, 16'h0002);
    rc(8'hE5, 16'hFFFE);
    rc(8'hE6, 16'h8000);
    rc(8'hF0, 16'h0002);
    rc(8'hF1, 16'h0003);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rc(8'hE4, 16'h0000);
    rc(8'hF0, 16'h0001);
    rc(8'hF2, 16'h0000);
    end_sim;
  end
endmodule
bind ftac_cycle_counter ftac_cycle_counter_props props_u (
  .core_clk(core_clk), .srst(srst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdDataQ(regRdDataQ), .seqOneStart(seqOneStart),
  .seqTwoStart(seqTwoStart), .cycleDone(cycleDone),
  .cycleError(cycleError), .irq(irq));
`default_nettype wire
